// [include/nfc_defs.svh]
`ifndef NFC_DEFS_SVH
`define NFC_DEFS_SVH

// feature bit positions
`define NFC_F_CSUM 0
`define NFC_F_GUEST_CSUM 1
`define NFC_F_CTRL_OFFL 2
`define NFC_F_MAC 5
`define NFC_F_GSO 6
`define NFC_F_GUEST_TSO4 7
`define NFC_F_GUEST_TSO6 8
`define NFC_F_GUEST_ECN 9
`define NFC_F_GUEST_UFO 10
`define NFC_F_HOST_TSO4 11
`define NFC_F_HOST_TSO6 12
`define NFC_F_HOST_ECN 13
`define NFC_F_HOST_UFO 14
`define NFC_F_MRG_RXBUF 15
`define NFC_F_STATUS 16
`define NFC_F_CTRL_VQ 17
`define NFC_F_CTRL_RX 18
`define NFC_F_CTRL_VLAN 19
`define NFC_F_ANNOUNCE 21
`define NFC_F_MQ 22
`define NFC_F_CTRL_MAC 23
// status word flag values
`define NFC_S_LINK_UP 16'h0001
`define NFC_S_ANNOUNCE 16'h0002
// queue pair limit bounds
`define NFC_QP_MIN 16'h0001
`define NFC_QP_MAX 16'h8000
// device-side spaces and config byte offsets
`define NFC_SP_ID 2'h0
`define NFC_SP_DEVF 2'h1
`define NFC_SP_DRVF 2'h2
`define NFC_SP_CFG 2'h3
`define NFC_CFG_W0 4'h0
`define NFC_CFG_W1 4'h4
`define NFC_CFG_W2 4'h8
`define NFC_BE_ALL 4'hF
`define NFC_BE_LO2 4'h3
// apb register offsets
`define NFC_R_CTRL 12'h000
`define NFC_R_WANT 12'h004
`define NFC_R_STAT 12'h008
`define NFC_R_OFFER 12'h00C
`define NFC_R_ACCEPT 12'h010
`define NFC_R_ADDR_LO 12'h014
`define NFC_R_ADDR_HI 12'h018
`define NFC_R_LINK 12'h01C
`define NFC_R_QPLIM 12'h020
`define NFC_R_QINFO 12'h024
`define NFC_R_DEVID 12'h028
`define NFC_R_NADDR_LO 12'h02C
`define NFC_R_NADDR_HI 12'h030
// control register bits
`define NFC_C_START 0
`define NFC_C_LEGACY 1
`define NFC_C_BIGEND 2
`define NFC_C_SETADDR 3
`endif

// [include/nfc_pkg.sv]
package nfc_pkg;
	typedef enum logic [3:0] {
		NFC_IDLE,
		NFC_RD_ID,
		NFC_RD_FEAT,
		NFC_WR_FEAT,
		NFC_RD_CFG0,
		NFC_RD_CFG1,
		NFC_RD_CFG2,
		NFC_WR_ADDR0,
		NFC_WR_ADDR1,
		NFC_DONE
	} nfc_state_e;
	typedef logic [31:0] nfc_word_t;
endpackage

// [sim/nfc_dev_model.sv]
`timescale 1ns/1ns
`include "nfc_defs.svh"
// device end of the transport: type code, feature words, config space
module nfc_dev_model #(
	parameter logic [47:0] MAC0 = 48'h0
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// transport port
	input wire logic dev_req,
	input wire logic dev_we,
	input wire logic [1:0] dev_space,
	input wire logic [3:0] dev_addr,
	input wire logic [3:0] dev_be,
	input wire logic [31:0] dev_wdata,
	output logic dev_ack,
	output logic [31:0] dev_rdata,
	// personality
	input wire logic [15:0] type_code,
	input wire logic [31:0] offer,
	input wire logic [15:0] link_word,
	input wire logic [15:0] qp_lim,
	input wire logic big_end,
	input wire logic [3:0] wait_n
);
	logic [47:0] station_address;
	logic [31:0] drv_feat;
	logic [31:0] val;
	logic [3:0] cnt;
	logic [15:0] lw_o;
	logic [15:0] qp_o;
	//////////////////////////////////////////////////////////////
	// a big-endian legacy guest sees 16-bit fields swapped
	assign lw_o = big_end ? {link_word[7:0], link_word[15:8]} : link_word;
	assign qp_o = big_end ? {qp_lim[7:0], qp_lim[15:8]} : qp_lim;
	// read value of each space; offer carries the feature bits
	always_comb begin
		case (dev_space)
			`NFC_SP_ID: val = {16'h0, type_code};
			`NFC_SP_DEVF: val = offer;
			`NFC_SP_DRVF: val = drv_feat;
			default: val = dev_addr == `NFC_CFG_W0 ? station_address[31:0] : dev_addr == `NFC_CFG_W1 ?
				{lw_o, station_address[47:32]} : {16'h0, qp_o};
		endcase
	end
	// slow answers on demand; data lines toggle when not answering
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dev_ack <= 1'b0;
			cnt <= 4'h0;
			dev_rdata <= 32'h0;
		end else if (dev_req && !dev_ack && cnt >= wait_n) begin
			dev_ack <= 1'b1;
			cnt <= 4'h0;
			dev_rdata <= val;
		end else begin
			dev_ack <= 1'b0;
			cnt <= dev_req && !dev_ack ? cnt + 4'h1 : 4'h0;
			dev_rdata <= ~dev_rdata;
		end
	end
	// writes land at the acknowledged edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			station_address <= MAC0;
			drv_feat <= 32'h0;
		end else if (dev_req && dev_ack && dev_we) begin
			if (dev_space == `NFC_SP_DRVF)
				drv_feat <= dev_wdata;
			if (dev_space == `NFC_SP_CFG)
				for (int i = 0; i < 4; i++)
					if (dev_be[i] && i + dev_addr < 6)
						station_address[8*(i+dev_addr) +: 8] <= dev_wdata[8*i +: 8];
		end
	end
endmodule

// [sim/nfc_host_chk_sva.sv]
`timescale 1ns/1ns
// protocol watch on the host's apb and transport ports
module nfc_host_chk #(
	parameter logic [15:0] NET_DEVICE_ID = 16'h00A5 // arbitrary value, set per system
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic [11:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	// transport
	input wire logic dev_req,
	input wire logic dev_we,
	input wire logic [1:0] dev_space,
	input wire logic [3:0] dev_addr,
	input wire logic [3:0] dev_be,
	input wire logic [31:0] dev_wdata,
	input wire logic dev_ack,
	input wire logic [31:0] dev_rdata
);
	logic [31:0] offered_ff;
	logic bad_addr;
	logic drv_wr;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	//////////////////////////////////////////////////////////////
	// decoded helpers
	assign bad_addr = paddr[1:0] != 2'h0 || paddr > 12'h030;
	assign drv_wr = dev_req && dev_we && dev_space == 2'h2;
	// offered word kept so the driver write can be held against it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			offered_ff <= 32'h0;
		else if (dev_req && dev_ack && dev_space == 2'h1)
			offered_ff <= dev_rdata;
	end
	//////////////////////////////////////////////////////////////
	property p_zero_wait;
		psel |-> pready == penable;
	endproperty
	a_zero_wait: assert property (p_zero_wait) else $error("pready wrong");
	property p_bad_addr;
		psel && !penable |=> pslverr == $past(bad_addr);
	endproperty
	a_bad_addr: assert property (p_bad_addr) else $error("pslverr wrong");
	property p_hold;
		dev_req && !dev_ack |=> dev_req && $stable(dev_space) && $stable(dev_addr) && $stable(dev_we)
			&& $stable(dev_be) && $stable(dev_wdata);
	endproperty
	a_hold: assert property (p_hold) else $error("request dropped before ack");
	property p_first_id;
		$rose(dev_req) |-> dev_space == 2'h0 && !dev_we;
	endproperty
	a_first_id: assert property (p_first_id) else $error("sequence not opened by type read");
	property p_id_ok;
		dev_req && dev_ack && dev_space == 2'h0 && dev_rdata[15:0] == NET_DEVICE_ID |=> dev_req && dev_space == 2'h1;
	endproperty
	a_id_ok: assert property (p_id_ok) else $error("no feature read after good type");
	property p_id_bad;
		dev_req && dev_ack && dev_space == 2'h0 && dev_rdata[15:0] != NET_DEVICE_ID |=> !dev_req [*4];
	endproperty
	a_id_bad: assert property (p_id_bad) else $error("went on after wrong type");
	property p_subset;
		drv_wr |-> (dev_wdata & ~offered_ff) == 32'h0;
	endproperty
	a_subset: assert property (p_subset) else $error("accepted bit not offered");
	property p_drv_dep;
		drv_wr |-> (!(dev_wdata[7] || dev_wdata[8] || dev_wdata[10]) || dev_wdata[1])
			&& (!dev_wdata[9] || dev_wdata[7] || dev_wdata[8]);
	endproperty
	a_drv_dep: assert property (p_drv_dep) else $error("driver offload dependency");
	property p_dev_dep;
		drv_wr |-> (!(dev_wdata[11] || dev_wdata[12] || dev_wdata[14]) || dev_wdata[0])
			&& (!dev_wdata[13] || dev_wdata[11] || dev_wdata[12]);
	endproperty
	a_dev_dep: assert property (p_dev_dep) else $error("device offload dependency");
	property p_ctrl_dep;
		drv_wr && (dev_wdata & 32'h00EC_0000) != 32'h0 |-> dev_wdata[17];
	endproperty
	a_ctrl_dep: assert property (p_ctrl_dep) else $error("control channel dependency");
	property p_cfg_walk;
		dev_req && dev_ack && !dev_we && dev_space == 2'h3 && dev_addr < 4'h8
			|=> dev_req && !dev_we && dev_space == 2'h3 && dev_addr == $past(dev_addr) + 4'h4;
	endproperty
	a_cfg_walk: assert property (p_cfg_walk) else $error("config words out of order");
	property p_cfg_wr;
		dev_req && dev_we && dev_space == 2'h3 |-> dev_addr == 4'h0 && dev_be == 4'hF || dev_addr == 4'h4 && dev_be == 4'h3;
	endproperty
	a_cfg_wr: assert property (p_cfg_wr) else $error("address write outside its six bytes");
endmodule
bind nfc_host nfc_host_chk #(.NET_DEVICE_ID(NET_DEVICE_ID)) u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
	.pslverr(pslverr), .dev_req(dev_req), .dev_we(dev_we), .dev_space(dev_space), .dev_addr(dev_addr),
	.dev_be(dev_be), .dev_wdata(dev_wdata), .dev_ack(dev_ack), .dev_rdata(dev_rdata)
);

// [sim/testbench.sv]
`timescale 1ns/1ns
`include "nfc_defs.svh"
module testbench;
	localparam logic [15:0] NET_ID = 16'h005A; // arbitrary type code
	localparam logic [47:0] MAC0 = 48'hC5B4_A392_8170;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, dev_req, dev_we, dev_ack, big_end, ev;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, dev_wdata, dev_rdata, offer, rv;
	logic [1:0] dev_space;
	logic [3:0] dev_addr, dev_be, wait_n;
	logic [15:0] type_code, link_word, qp_lim;
	int n_fail = 0;
	int checks_done = 0;
	//////////////////////////////////////////////////////////////
	nfc_host #(.NET_DEVICE_ID(NET_ID)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.dev_req(dev_req), .dev_we(dev_we), .dev_space(dev_space), .dev_addr(dev_addr), .dev_be(dev_be),
		.dev_wdata(dev_wdata), .dev_ack(dev_ack), .dev_rdata(dev_rdata));
	nfc_dev_model #(.MAC0(MAC0)) dev (.pclk(pclk), .presetn(presetn), .dev_req(dev_req), .dev_we(dev_we),
		.dev_space(dev_space), .dev_addr(dev_addr), .dev_be(dev_be), .dev_wdata(dev_wdata), .dev_ack(dev_ack),
		.dev_rdata(dev_rdata), .type_code(type_code), .offer(offer), .link_word(link_word), .qp_lim(qp_lim),
		.big_end(big_end), .wait_n(wait_n));
	//////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one apb transfer; result left in rv and ev
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// no wait count assumed; only the watchdog ends a hung access
		while (pready !== 1'b1)
			@(posedge pclk);
		rv = prdata;
		ev = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// accepted set worked out from offer, wish and interface flavour
	function automatic logic [31:0] exp_acc(input logic [31:0] o, input logic [31:0] w, input logic lg);
		logic [31:0] a;
		a = o & w;
		a[6] = a[6] & lg;
		if (!a[1])
			a = a & ~32'h0000_0580;
		if (!(a[7] || a[8]))
			a[9] = 1'b0;
		if (!a[0])
			a = a & ~32'h0000_5800;
		if (!(a[11] || a[12]))
			a[13] = 1'b0;
		if (!a[17])
			a = a & ~32'h00EC_0000;
		return a;
	endfunction
	// one negotiation, then every result register; only stat and devid after a foreign type code
	task automatic run(input int t, input logic [15:0] tc, input logic [31:0] off, input logic [31:0] wnt,
		input logic [3:0] ctl, input logic [15:0] lw, input logic [15:0] qp, input logic [3:0] wn);
		logic [31:0] a;
		int k;
		k = 0;
		type_code <= tc;
		offer <= off;
		link_word <= lw;
		qp_lim <= qp;
		big_end <= ctl[2] && ctl[1];
		wait_n <= wn;
		apb(1'b1, `NFC_R_WANT, wnt);
		apb(1'b1, `NFC_R_NADDR_LO, 32'h4433_2211);
		apb(1'b1, `NFC_R_NADDR_HI, 32'h0000_6655);
		apb(1'b1, `NFC_R_CTRL, {28'h0, ctl | 4'h1});
		apb(1'b1, `NFC_R_WANT, 32'h0);
		rv = 32'h0;
		while (rv[1] !== 1'b1 && k < 300) begin
			apb(1'b0, `NFC_R_STAT, 32'h0);
			k++;
		end
		a = exp_acc(off, wnt, ctl[1]);
		if (tc !== NET_ID) begin
			chk("stat", 32'h2, rv);
		end else begin
			chk("stat", {28'h0, off[22] && (qp == 16'h0 || qp > 16'h8000), 3'b110}, rv);
			apb(1'b0, `NFC_R_WANT, 32'h0);
			chk("want", wnt, rv);
			apb(1'b0, `NFC_R_OFFER, 32'h0);
			chk("offer", off, rv);
			apb(1'b0, `NFC_R_CTRL, 32'h0);
			chk("ctrl", {28'h0, ctl & 4'hE}, rv);
			apb(1'b0, `NFC_R_ACCEPT, 32'h0);
			chk("accept", a, rv);
			chk("drv_feat", a, dev.drv_feat);
			apb(1'b0, `NFC_R_ADDR_LO, 32'h0);
			chk("addr_lo", a[5] ? MAC0[31:0] : 32'h0, rv);
			apb(1'b0, `NFC_R_ADDR_HI, 32'h0);
			chk("addr_hi", a[5] ? {16'h0, MAC0[47:32]} : 32'h0, rv);
			apb(1'b0, `NFC_R_LINK, 32'h0);
			chk("link", a[16] ? {16'h0, lw & 16'h0003} : 32'h1, rv);
			apb(1'b0, `NFC_R_QPLIM, 32'h0);
			chk("qplim", a[22] ? {16'h0, qp} : 32'h0, rv);
			apb(1'b0, `NFC_R_QINFO, 32'h0);
			chk("qinfo", {a[17], 16'h1}, {rv[31], rv[15:0]});
			if (a[17])
				chk("ctrl_idx", 14'(2 * (a[22] ? qp : 16'h1) + 2), rv[29:16]);
			chk("station", ctl[3] && ctl[1] ? 48'h6655_4433_2211 : MAC0, dev.station_address);
		end
		apb(1'b0, `NFC_R_DEVID, 32'h0);
		chk("devid", {16'h0, tc}, rv);
		$display("test %0d done", t);
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	//////////////////////////////////////////////////////////////
	// clock
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	// watchdog, far beyond the few hundred cycles the whole bench takes
	initial begin
		repeat (8000) @(posedge pclk);
		n_fail++;
		final_report;
	end
	// main sequence
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		type_code = NET_ID;
		offer = 32'h0;
		link_word = 16'h0;
		qp_lim = 16'h0;
		big_end = 1'b0;
		wait_n = 4'h0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `NFC_R_STAT, 32'h0);
		chk("stat_rst", 32'h0, rv);
		apb(1'b0, `NFC_R_ACCEPT, 32'h0);
		chk("acc_rst", 32'h0, rv);
		apb(1'b0, 12'h034, 32'h0);
		chk("unmapped", 33'h1_0000_0000, {ev, rv});
		apb(1'b1, 12'h006, 32'h0);
		chk("misaligned", 1'b1, ev);
		$display("test 0 done");
		run(1, NET_ID, 32'h00EF_FFE7, 32'hFFFF_FFFF, 4'h0, 16'h0003, 16'h0004, 4'h0);
		run(2, NET_ID, 32'h00EF_FFE7, 32'h00EC_FFC4, 4'hC, 16'h0001, 16'h8001, 4'h3);
		run(3, NET_ID, 32'h00EF_FFE7, 32'h00EF_FFE7, 4'hE, 16'h0002, 16'h0100, 4'h1);
		run(4, NET_ID ^ 16'h0001, 32'h00EF_FFE7, 32'hFFFF_FFFF, 4'h0, 16'h0001, 16'h0001, 4'h0);
		final_report;
	end
endmodule

// [verilog/nfc_feat_filter.sv]
`timescale 1ns/1ns
`include "nfc_defs.svh"
// trims the wanted feature set to what is offered and self-consistent
module nfc_feat_filter (
	// feature sets
	input wire logic [31:0] offered,
	input wire logic [31:0] wanted,
	// interface flavour
	input wire logic legacy,
	// result
	output logic [31:0] accepted
);
	logic [31:0] base;
	logic g_tso;
	logic h_tso;

	// dependencies resolved in one pass; parents never depend on children
	always_comb begin
		base = offered & wanted;
		base[`NFC_F_GSO] = base[`NFC_F_GSO] & legacy;
		accepted = base;
		accepted[`NFC_F_GUEST_TSO4] = base[`NFC_F_GUEST_TSO4] & base[`NFC_F_GUEST_CSUM];
		accepted[`NFC_F_GUEST_TSO6] = base[`NFC_F_GUEST_TSO6] & base[`NFC_F_GUEST_CSUM];
		accepted[`NFC_F_GUEST_UFO] = base[`NFC_F_GUEST_UFO] & base[`NFC_F_GUEST_CSUM];
		g_tso = accepted[`NFC_F_GUEST_TSO4] | accepted[`NFC_F_GUEST_TSO6];
		accepted[`NFC_F_GUEST_ECN] = base[`NFC_F_GUEST_ECN] & g_tso;
		accepted[`NFC_F_HOST_TSO4] = base[`NFC_F_HOST_TSO4] & base[`NFC_F_CSUM];
		accepted[`NFC_F_HOST_TSO6] = base[`NFC_F_HOST_TSO6] & base[`NFC_F_CSUM];
		accepted[`NFC_F_HOST_UFO] = base[`NFC_F_HOST_UFO] & base[`NFC_F_CSUM];
		h_tso = accepted[`NFC_F_HOST_TSO4] | accepted[`NFC_F_HOST_TSO6];
		accepted[`NFC_F_HOST_ECN] = base[`NFC_F_HOST_ECN] & h_tso;
		accepted[`NFC_F_CTRL_RX] = base[`NFC_F_CTRL_RX] & base[`NFC_F_CTRL_VQ];
		accepted[`NFC_F_CTRL_VLAN] = base[`NFC_F_CTRL_VLAN] & base[`NFC_F_CTRL_VQ];
		accepted[`NFC_F_ANNOUNCE] = base[`NFC_F_ANNOUNCE] & base[`NFC_F_CTRL_VQ];
		accepted[`NFC_F_MQ] = base[`NFC_F_MQ] & base[`NFC_F_CTRL_VQ];
		accepted[`NFC_F_CTRL_MAC] = base[`NFC_F_CTRL_MAC] & base[`NFC_F_CTRL_VQ];
	end
endmodule

// [verilog/nfc_host.sv]
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ns
`include "nfc_defs.svh"
// driver-side negotiation engine for a paravirtual network device
module nfc_host #(
	parameter logic [15:0] NET_DEVICE_ID = 16'h00A5, // arbitrary value, set per system
	parameter int QP_W = 16
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// device transport port
	output logic dev_req,
	output logic dev_we,
	output logic [1:0] dev_space,
	output logic [3:0] dev_addr,
	output logic [3:0] dev_be,
	output logic [31:0] dev_wdata,
	input wire logic dev_ack,
	input wire logic [31:0] dev_rdata
);
	nfc_pkg::nfc_state_e state_ff;
	nfc_pkg::nfc_state_e nxt_state;
	logic legacy_ff;
	logic bigend_ff;
	logic setaddr_ff;
	nfc_pkg::nfc_word_t want_ff;
	nfc_pkg::nfc_word_t offer_ff;
	nfc_pkg::nfc_word_t accept_ff;
	nfc_pkg::nfc_word_t accept_c;
	nfc_pkg::nfc_word_t offer_c;
	logic [15:0] devid_ff;
	logic [47:0] addr_ff;
	logic [47:0] naddr_ff;
	logic [15:0] link_raw_ff;
	logic [15:0] qp_raw_ff;
	logic id_ok_ff;
	logic done_ff;
	logic qp_err_ff;
	logic [31:0] prdata_ff;
	logic req_ff;
	logic wr;
	logic setup;
	logic start;
	logic busy;
	logic xfer;
	logic [15:0] link_word;
	logic [15:0] qp_word;
	logic [QP_W-1:0] n_pairs;
	logic [QP_W+1:0] ctrl_idx;
	logic ctrl_present;

	// byte order as the guest sees a 16-bit config field
	function automatic logic [15:0] fix16(input logic [15:0] raw, input logic leg, input logic be);
		fix16 = (leg && be) ? {raw[7:0], raw[15:8]} : raw;
	endfunction

	//////////////////////////////////////////////////////////////////////////
	// apb slave: zero wait, data registered in the setup cycle

	assign setup = psel && !penable;
	assign wr = psel && penable && pwrite;
	assign pready = psel && penable;
	assign busy = (state_ff != nfc_pkg::NFC_IDLE) && (state_ff != nfc_pkg::NFC_DONE);
	// a start while busy is dropped so a run is never torn in half
	assign start = wr && (paddr == `NFC_R_CTRL) && pwdata[`NFC_C_START] && !busy;

	// unmapped offsets answer an error and read as zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else if (setup) begin
			pslverr <= (paddr[1:0] != 2'h0) || (paddr > `NFC_R_NADDR_HI);
		end
	end

	// control and wanted features
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			legacy_ff <= 1'b0;
			bigend_ff <= 1'b0;
			setaddr_ff <= 1'b0;
			want_ff <= 32'h0000_0000;
			naddr_ff <= 48'h0000_0000_0000;
		end else if (wr && !busy) begin
			case (paddr)
				`NFC_R_CTRL: begin
					legacy_ff <= pwdata[`NFC_C_LEGACY];
					bigend_ff <= pwdata[`NFC_C_BIGEND];
					setaddr_ff <= pwdata[`NFC_C_SETADDR];
				end
				`NFC_R_WANT: want_ff <= pwdata;
				`NFC_R_NADDR_LO: naddr_ff[31:0] <= pwdata;
				`NFC_R_NADDR_HI: naddr_ff[47:32] <= pwdata[15:0];
				default: ;
			endcase
		end
	end

	// read mux
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h0000_0000;
		end else if (setup) begin
			case (paddr)
				`NFC_R_CTRL: prdata_ff <= {28'h0, setaddr_ff, bigend_ff, legacy_ff, 1'b0};
				`NFC_R_WANT: prdata_ff <= want_ff;
				`NFC_R_STAT: prdata_ff <= {28'h0, qp_err_ff, id_ok_ff, done_ff, busy};
				`NFC_R_OFFER: prdata_ff <= offer_ff;
				`NFC_R_ACCEPT: prdata_ff <= accept_ff;
				// address is valid only when the device supplies it
				`NFC_R_ADDR_LO: prdata_ff <= accept_ff[`NFC_F_MAC] ? addr_ff[31:0] : 32'h0;
				`NFC_R_ADDR_HI: prdata_ff <= accept_ff[`NFC_F_MAC] ? {16'h0, addr_ff[47:32]} : 32'h0;
				`NFC_R_LINK: prdata_ff <= {16'h0, link_word};
				`NFC_R_QPLIM: prdata_ff <= {16'h0, qp_word};
				`NFC_R_QINFO: prdata_ff <= {ctrl_present, 1'b0, ctrl_idx[13:0], n_pairs};
				`NFC_R_DEVID: prdata_ff <= {16'h0, devid_ff};
				`NFC_R_NADDR_LO: prdata_ff <= naddr_ff[31:0];
				`NFC_R_NADDR_HI: prdata_ff <= {16'h0, naddr_ff[47:32]};
				default: prdata_ff <= 32'h0000_0000;
			endcase
		end
	end
	assign prdata = prdata_ff;

	//////////////////////////////////////////////////////////////////////////
	// negotiation sequencer

	// the offered word feeds the filter in the cycle it arrives, else the
	// driver write loaded at that same edge would carry the previous offer
	assign offer_c = (xfer && state_ff == nfc_pkg::NFC_RD_FEAT) ? dev_rdata : offer_ff;

	nfc_feat_filter u_filter (
		.offered(offer_c),
		.wanted(want_ff),
		.legacy(legacy_ff),
		.accepted(accept_c)
	);

	assign xfer = req_ff && dev_ack;

	// order: type code, offered set, accepted set, config words, address write
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			nfc_pkg::NFC_IDLE,
			nfc_pkg::NFC_DONE: begin
				if (start)
					nxt_state = nfc_pkg::NFC_RD_ID;
			end
			nfc_pkg::NFC_RD_ID: begin
				// a foreign type code ends the run before any negotiation
				if (xfer)
					nxt_state = (dev_rdata[15:0] == NET_DEVICE_ID) ? nfc_pkg::NFC_RD_FEAT : nfc_pkg::NFC_DONE;
			end
			nfc_pkg::NFC_RD_FEAT: if (xfer) nxt_state = nfc_pkg::NFC_WR_FEAT;
			nfc_pkg::NFC_WR_FEAT: if (xfer) nxt_state = nfc_pkg::NFC_RD_CFG0;
			nfc_pkg::NFC_RD_CFG0: if (xfer) nxt_state = nfc_pkg::NFC_RD_CFG1;
			nfc_pkg::NFC_RD_CFG1: if (xfer) nxt_state = nfc_pkg::NFC_RD_CFG2;
			nfc_pkg::NFC_RD_CFG2: begin
				// address write exists only on the legacy interface
				if (xfer)
					nxt_state = (legacy_ff && setaddr_ff) ? nfc_pkg::NFC_WR_ADDR0 : nfc_pkg::NFC_DONE;
			end
			nfc_pkg::NFC_WR_ADDR0: if (xfer) nxt_state = nfc_pkg::NFC_WR_ADDR1;
			nfc_pkg::NFC_WR_ADDR1: if (xfer) nxt_state = nfc_pkg::NFC_DONE;
			default: nxt_state = nfc_pkg::NFC_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			state_ff <= nfc_pkg::NFC_IDLE;
		else
			state_ff <= nxt_state;
	end

	// device request: raised on start, held until each ack, reloaded for the next step at that edge, dropped after the last
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_ff <= 1'b0;
			dev_we <= 1'b0;
			dev_space <= `NFC_SP_ID;
			dev_addr <= `NFC_CFG_W0;
			dev_be <= `NFC_BE_ALL;
			dev_wdata <= 32'h0000_0000;
		end else if (xfer || !req_ff) begin
			req_ff <= 1'b0;
			dev_we <= 1'b0;
			dev_be <= `NFC_BE_ALL;
			dev_addr <= `NFC_CFG_W0;
			dev_wdata <= 32'h0000_0000;
			if (nxt_state != state_ff) begin
				req_ff <= busy || (nxt_state == nfc_pkg::NFC_RD_ID);
				case (nxt_state)
					nfc_pkg::NFC_RD_ID: dev_space <= `NFC_SP_ID;
					nfc_pkg::NFC_RD_FEAT: dev_space <= `NFC_SP_DEVF;
					nfc_pkg::NFC_WR_FEAT: begin
						dev_space <= `NFC_SP_DRVF;
						dev_we <= 1'b1;
						dev_wdata <= accept_c;
					end
					nfc_pkg::NFC_RD_CFG0: dev_space <= `NFC_SP_CFG;
					nfc_pkg::NFC_RD_CFG1: begin
						dev_space <= `NFC_SP_CFG;
						dev_addr <= `NFC_CFG_W1;
					end
					nfc_pkg::NFC_RD_CFG2: begin
						dev_space <= `NFC_SP_CFG;
						dev_addr <= `NFC_CFG_W2;
					end
					nfc_pkg::NFC_WR_ADDR0: begin
						dev_space <= `NFC_SP_CFG;
						dev_we <= 1'b1;
						dev_wdata <= naddr_ff[31:0];
					end
					nfc_pkg::NFC_WR_ADDR1: begin
						// only the two address bytes; status stays untouched
						dev_space <= `NFC_SP_CFG;
						dev_addr <= `NFC_CFG_W1;
						dev_we <= 1'b1;
						dev_be <= `NFC_BE_LO2;
						dev_wdata <= {16'h0, naddr_ff[47:32]};
					end
					default: req_ff <= 1'b0;
				endcase
			end
		end
	end
	assign dev_req = req_ff;

	//////////////////////////////////////////////////////////////////////////
	// captured device state

	// result flags; a new start clears them, the run sets them again
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_ff <= 1'b0;
			id_ok_ff <= 1'b0;
			qp_err_ff <= 1'b0;
		end else if (start) begin
			done_ff <= 1'b0;
			id_ok_ff <= 1'b0;
			qp_err_ff <= 1'b0;
		end else begin
			if (nxt_state == nfc_pkg::NFC_DONE && state_ff != nfc_pkg::NFC_DONE)
				done_ff <= 1'b1;
			if (xfer && state_ff == nfc_pkg::NFC_RD_ID)
				id_ok_ff <= (dev_rdata[15:0] == NET_DEVICE_ID);
			// limit out of range is flagged when multiqueue is offered
			if (xfer && state_ff == nfc_pkg::NFC_RD_CFG2 && offer_ff[`NFC_F_MQ]) begin
				qp_err_ff <= (fix16(dev_rdata[15:0], legacy_ff, bigend_ff) < `NFC_QP_MIN) ||
					(fix16(dev_rdata[15:0], legacy_ff, bigend_ff) > `NFC_QP_MAX);
			end
		end
	end

	// captured words, little-endian byte order in the config space
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			devid_ff <= 16'h0000;
			offer_ff <= 32'h0000_0000;
			accept_ff <= 32'h0000_0000;
			addr_ff <= 48'h0000_0000_0000;
			link_raw_ff <= 16'h0000;
			qp_raw_ff <= 16'h0000;
		end else if (xfer) begin
			case (state_ff)
				nfc_pkg::NFC_RD_ID: devid_ff <= dev_rdata[15:0];
				nfc_pkg::NFC_RD_FEAT: offer_ff <= dev_rdata;
				nfc_pkg::NFC_WR_FEAT: accept_ff <= accept_c;
				nfc_pkg::NFC_RD_CFG0: addr_ff[31:0] <= dev_rdata;
				nfc_pkg::NFC_RD_CFG1: begin
					addr_ff[47:32] <= dev_rdata[15:0];
					link_raw_ff <= dev_rdata[31:16];
				end
				nfc_pkg::NFC_RD_CFG2: qp_raw_ff <= dev_rdata[15:0];
				default: ;
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// derived views

	// without the status feature the link is taken as up, no announce
	assign link_word = accept_ff[`NFC_F_STATUS] ?
		(fix16(link_raw_ff, legacy_ff, bigend_ff) & (`NFC_S_LINK_UP | `NFC_S_ANNOUNCE)) :
		`NFC_S_LINK_UP;
	// limit reads zero unless multiqueue was accepted
	assign qp_word = accept_ff[`NFC_F_MQ] ? fix16(qp_raw_ff, legacy_ff, bigend_ff) : 16'h0000;
	// pairs in use start at one even with multiqueue
	assign n_pairs = QP_W'(`NFC_QP_MIN);
	assign ctrl_present = accept_ff[`NFC_F_CTRL_VQ];
	// control index is twice the queue pair limit plus two (4 without multiqueue or with a zero limit), zero if absent
	assign ctrl_idx = !ctrl_present ? '0 :
		(accept_ff[`NFC_F_MQ] && qp_word != 16'h0000) ?
		((QP_W+2)'(qp_word) << 1) + (QP_W+2)'(2) :
		(QP_W+2)'(4);
endmodule
